// [dv/bit_shift_flag_unit_tb_top.sv]
// Self-checking bench for the bit, shift and flag execution unit.
// Assumes the package is compiled first; drives ports directly.
`timescale 1ns/1ns
module bit_shift_flag_unit_tb_top
  import bit_shift_flag_pkg::*;
;
  // ===========================================================
  // Stimulus, outputs and reference state
  logic sys_clk;
  logic rst;
  logic op_valid;
  op_e op_code;
  logic [7:0] reg_in;
  logic [2:0] bit_sel;
  logic [2:0] flag_sel;
  logic [7:0] io_in;
  logic busy_q;
  logic done_q;
  logic [7:0] result_q;
  logic result_we_q;
  logic [7:0] io_out_q;
  logic io_we_q;
  logic [7:0] status_q;
  logic [7:0] st;
  int n_mismatch;
  int checks;
  int cycles;

  bit_shift_flag_unit dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .op_valid(op_valid),
    .op_code(op_code),
    .reg_in(reg_in),
    .bit_sel(bit_sel),
    .flag_sel(flag_sel),
    .io_in(io_in),
    .busy_q(busy_q),
    .done_q(done_q),
    .result_q(result_q),
    .result_we_q(result_we_q),
    .io_out_q(io_out_q),
    .io_we_q(io_we_q),
    .status_q(status_q)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ===========================================================
  // Compare, run and closing tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  // Reference computed here, never read back from the unit
  task automatic run(input op_e op, input logic [7:0] r,
                     input logic [2:0] b, input logic [2:0] f,
                     input logic [7:0] io);
    logic [7:0] er;
    logic [7:0] eio;
    logic ec;
    logic rw;
    er = r;
    eio = io;
    ec = st[0];
    rw = 1'b1;
    case (op)
      shift_left_logical_op: {ec, er} = {r, 1'b0};
      shift_right_logical_op: {er, ec} = {1'b0, r};
      rotate_left_carry_op: {ec, er} = {r, st[0]};
      rotate_right_carry_op: {er, ec} = {st[0], r};
      shift_right_arith_op: {er, ec} = {r[7], r};
      swap_nibbles_op: er = {r[3:0], r[7:4]};
      transfer_flag_to_bit_op: er[b] = st[6];
      default: rw = 1'b0;
    endcase
    if (op inside {[shift_left_logical_op:shift_right_arith_op]})
      st[3:0] = {er[7] ^ ec, er[7], er == 8'h00, ec};
    if (op == bit_to_transfer_flag_op)
      st[6] = r[b];
    if (op == flag_set_generic_op)
      st[f] = 1'b1;
    if (op == flag_clear_generic_op)
      st[f] = 1'b0;
    eio[b] = (op == io_bit_set_op);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code = op;
    reg_in = r;
    bit_sel = b;
    flag_sel = f;
    io_in = io;
    @(negedge sys_clk);
    op_valid = 1'b0;
    if (op == io_bit_set_op || op == io_bit_clear_op)
    begin
      chk_bit(busy_q, 1'b1);
      chk_byte(io_out_q, eio);
      chk_bit(done_q, 1'b0);
      @(negedge sys_clk);
      chk_bit(io_we_q, 1'b1);
      chk_bit(busy_q, 1'b0);
      rw = 1'b0;
    end
    chk_bit(done_q, 1'b1);
    chk_bit(result_we_q, rw);
    if (rw)
      chk_byte(result_q, er);
    chk_byte(status_q, st);
  endtask : run

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Ceiling well above the roughly 150 cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ===========================================================
  // Test sequence
  initial
  begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = op_none;
    reg_in = 8'h00;
    bit_sel = 3'h0;
    flag_sel = 3'h0;
    io_in = 8'h00;
    st = 8'h00;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    chk_byte(status_q, 8'h00);
    chk_bit(done_q | busy_q | result_we_q | io_we_q, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      run(flag_set_generic_op, 8'hff, 3'h0, 3'(i), 8'h00);
    for (int i = 0; i < 8; i++)
      run(flag_clear_generic_op, 8'h00, 3'h0, 3'(i), 8'h00);
    $display("test flags done");
    run(flag_set_generic_op, 8'h00, 3'h0, 3'h0, 8'h00);
    run(shift_left_logical_op, 8'h81, 3'h0, 3'h0, 8'h00);
    run(shift_right_logical_op, 8'h01, 3'h0, 3'h0, 8'h00);
    run(rotate_left_carry_op, 8'h40, 3'h0, 3'h0, 8'h00);
    run(rotate_right_carry_op, 8'h02, 3'h0, 3'h0, 8'h00);
    run(rotate_right_carry_op, 8'h01, 3'h0, 3'h0, 8'h00);
    run(rotate_left_carry_op, 8'h00, 3'h0, 3'h0, 8'h00);
    run(shift_right_arith_op, 8'h81, 3'h0, 3'h0, 8'h00);
    run(shift_right_arith_op, 8'h7e, 3'h0, 3'h0, 8'h00);
    run(swap_nibbles_op, 8'h3c, 3'h0, 3'h0, 8'h00);
    $display("test shifts done");
    for (int i = 0; i < 8; i++)
    begin
      run(bit_to_transfer_flag_op, 8'ha5, 3'(i), 3'h0, 8'h00);
      run(transfer_flag_to_bit_op, 8'h5a, 3'(i), 3'h0, 8'h00);
    end
    $display("test transfer flag done");
    for (int i = 0; i < 8; i++)
    begin
      run(io_bit_set_op, 8'h00, 3'(i), 3'h0, 8'h5a);
      run(io_bit_clear_op, 8'h00, 3'(i), 3'h0, 8'h5a);
    end
    $display("test io bits done");
    run(no_operation_op, 8'hff, 3'h7, 3'h7, 8'hff);
    run(op_none, 8'h00, 3'h0, 3'h0, 8'h00);
    $display("test no operation done");
    // Second request held only while busy must be ignored
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code = io_bit_set_op;
    bit_sel = 3'h0;
    io_in = 8'h00;
    @(negedge sys_clk);
    op_code = flag_set_generic_op;
    flag_sel = 3'h7;
    @(negedge sys_clk);
    op_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_byte(status_q, st);
    $display("test busy refusal done");
    complete_run();
  end

endmodule : bit_shift_flag_unit_tb_top

// [rtl/bit_shift_flag_pkg.sv]
// Types shared by the bit, shift and flag execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bit_shift_flag_pkg;

  // ===========================================================
  // Operation codes presented by the decoder
  typedef enum logic [3:0] {
    op_none,
    no_operation_op,
    io_bit_set_op,
    io_bit_clear_op,
    shift_left_logical_op,
    shift_right_logical_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    shift_right_arith_op,
    swap_nibbles_op,
    flag_set_generic_op,
    flag_clear_generic_op,
    bit_to_transfer_flag_op,
    transfer_flag_to_bit_op
  } op_e;

  // ===========================================================
  // Sequencer states
  typedef enum logic {
    st_idle,
    st_io_write
  } state_e;

endpackage : bit_shift_flag_pkg

// [rtl/bit_shift_flag_unit.sv]
// Execution unit for bit, shift, rotate, swap and status flag operations.
// Assumes a decoder presents one operation with op_valid while busy_q low.
`timescale 1ns/1ns
`include "bit_shift_flag_unit_consts.svh"
module bit_shift_flag_unit
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_valid,
  input bit_shift_flag_pkg::op_e op_code,
  input wire logic [7:0] reg_in,
  input wire logic [2:0] bit_sel,
  input wire logic [2:0] flag_sel,
  input wire logic [7:0] io_in,
  output logic busy_q,
  output logic done_q,
  output logic [7:0] result_q,
  output logic result_we_q,
  output logic [7:0] io_out_q,
  output logic io_we_q,
  output logic [7:0] status_q
);
  import bit_shift_flag_pkg::*;

  // ===========================================================
  // Decode
  state_e state_q;
  state_e state_d;
  logic [7:0] result_d;
  logic result_we_d;
  logic [7:0] io_out_d;
  logic io_we_d;
  logic [7:0] status_d;
  logic done_d;
  logic [7:0] sh_res;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  wire take = op_valid && (state_q == st_idle);
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] flag_mask = 8'h01 << flag_sel;
  wire is_shift = (op_code == shift_left_logical_op)
    || (op_code == shift_right_logical_op)
    || (op_code == rotate_left_carry_op)
    || (op_code == rotate_right_carry_op)
    || (op_code == shift_right_arith_op);
  wire [7:0] sznv_mask = (8'h01 << `FLAG_C) | (8'h01 << `FLAG_Z)
    | (8'h01 << `FLAG_N) | (8'h01 << `FLAG_V);
  wire [7:0] shift_flags = ({7'h00, sh_c} << `FLAG_C)
    | ({7'h00, sh_z} << `FLAG_Z) | ({7'h00, sh_n} << `FLAG_N)
    | ({7'h00, sh_v} << `FLAG_V);
  wire [7:0] shift_status = (status_q & ~sznv_mask) | shift_flags;
  wire t_flag = status_q[`FLAG_T];
  wire [7:0] t_mask = 8'h01 << `FLAG_T;

  shift_rotate_core u_shift (
    .op(op_code),
    .value(reg_in),
    .carry_in(status_q[`FLAG_C]),
    .res(sh_res),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v)
  );

  // ===========================================================
  // Next state
  always_comb
  begin
    state_d = state_q;
    result_d = result_q;
    result_we_d = 1'b0;
    io_out_d = io_out_q;
    io_we_d = 1'b0;
    status_d = status_q;
    done_d = 1'b0;
    case (state_q)
      st_idle:
      begin
        if (take)
        begin
          done_d = 1'b1;
          if (is_shift)
          begin
            result_d = sh_res;
            result_we_d = 1'b1;
            status_d = shift_status;
          end
          case (op_code)
            io_bit_set_op:
            begin
              // Write waits a cycle so the port sees a stable value
              io_out_d = io_in | bit_mask;
              state_d = st_io_write;
              done_d = 1'b0;
            end
            io_bit_clear_op:
            begin
              io_out_d = io_in & ~bit_mask;
              state_d = st_io_write;
              done_d = 1'b0;
            end
            swap_nibbles_op:
            begin
              result_d = {reg_in[3:0], reg_in[7:4]};
              result_we_d = 1'b1;
            end
            flag_set_generic_op:
              status_d = status_q | flag_mask;
            flag_clear_generic_op:
              status_d = status_q & ~flag_mask;
            bit_to_transfer_flag_op:
              status_d = reg_in[bit_sel] ? (status_q | t_mask)
                : (status_q & ~t_mask);
            transfer_flag_to_bit_op:
            begin
              result_d = t_flag ? (reg_in | bit_mask)
                : (reg_in & ~bit_mask);
              result_we_d = 1'b1;
            end
            default:
              state_d = st_idle;
          endcase
        end
      end
      st_io_write:
      begin
        io_we_d = 1'b1;
        done_d = 1'b1;
        state_d = st_idle;
      end
      default:
        state_d = st_idle;
    endcase
  end

  // ===========================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= `DATA_RESET;
      result_we_q <= 1'b0;
      io_out_q <= `DATA_RESET;
      io_we_q <= 1'b0;
      status_q <= `STATUS_RESET;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= (state_d != st_idle);
      done_q <= done_d;
      result_q <= result_d;
      result_we_q <= result_we_d;
      io_out_q <= io_out_d;
      io_we_q <= io_we_d;
      status_q <= status_d;
    end
  end

  // ===========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_io_take(op_e kind);
    take && (op_code == kind);
  endsequence
  sequence s_io_finish;
    busy_q && !io_we_q ##1 io_we_q && done_q && !busy_q;
  endsequence

  property p_io_set;
    s_io_take(io_bit_set_op) |=> s_io_finish ##0
      (io_out_q == ($past(io_in, 2) | (8'h01 << $past(bit_sel, 2))))
      && (status_q == $past(status_q, 2));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set wrong");

  property p_io_clear;
    s_io_take(io_bit_clear_op) |=> s_io_finish ##0
      (io_out_q == ($past(io_in, 2) & ~(8'h01 << $past(bit_sel, 2))))
      && !result_we_q;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io clr bad");

  property p_lsl;
    take && (op_code == shift_left_logical_op) |=> result_we_q && done_q
      && (result_q == {$past(reg_in[6:0]), 1'b0})
      && (status_q[`FLAG_C] == $past(reg_in[7]));
  endproperty
  a_lsl: assert property (p_lsl) else $error("lsl wrong");

  property p_lsr;
    take && (op_code == shift_right_logical_op) |=>
      (result_q == {1'b0, $past(reg_in[7:1])}) && !status_q[`FLAG_N]
      && (status_q[`FLAG_V] == status_q[`FLAG_C]);
  endproperty
  a_lsr: assert property (p_lsr) else $error("lsr wrong");

  property p_rol;
    take && (op_code == rotate_left_carry_op) |=>
      (result_q == {$past(reg_in[6:0]), $past(status_q[`FLAG_C])})
      && (status_q[`FLAG_Z] == (result_q == 8'h00));
  endproperty
  a_rol: assert property (p_rol) else $error("rol wrong");

  property p_ror;
    take && (op_code == rotate_right_carry_op) |=>
      (result_q == {$past(status_q[`FLAG_C]), $past(reg_in[7:1])})
      && (status_q[`FLAG_C] == $past(reg_in[0]));
  endproperty
  a_ror: assert property (p_ror) else $error("ror wrong");

  property p_asr;
    take && (op_code == shift_right_arith_op) |=>
      (result_q == {$past(reg_in[7]), $past(reg_in[7:1])})
      && (status_q[`FLAG_S] == $past(status_q[`FLAG_S]));
  endproperty
  a_asr: assert property (p_asr) else $error("asr wrong");

  property p_swap;
    take && (op_code == swap_nibbles_op) |=> $stable(status_q)
      && (result_q == {$past(reg_in[3:0]), $past(reg_in[7:4])});
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_bst;
    take && (op_code == bit_to_transfer_flag_op) |=> !result_we_q
      && (status_q[`FLAG_T] == $past(reg_in[bit_sel]))
      && ((status_q & ~t_mask) == ($past(status_q) & ~t_mask));
  endproperty
  a_bst: assert property (p_bst) else $error("bst wrong");

  property p_bld;
    take && (op_code == transfer_flag_to_bit_op) |=> $stable(status_q)
      && (result_q[$past(bit_sel)] == status_q[`FLAG_T])
      && (((result_q ^ $past(reg_in))
      & ~(8'h01 << $past(bit_sel))) == 8'h00);
  endproperty
  a_bld: assert property (p_bld) else $error("bld wrong");

  property p_flag_set;
    take && (op_code == flag_set_generic_op) |=>
      (status_q == ($past(status_q) | (8'h01 << $past(flag_sel))));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("set wrong");

  property p_flag_clear;
    take && (op_code == flag_clear_generic_op) |=>
      (status_q == ($past(status_q) & ~(8'h01 << $past(flag_sel))));
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag clear wrong");

  property p_nop;
    take && (op_code == no_operation_op) |=> done_q && $stable(status_q)
      && !result_we_q && !io_we_q && !busy_q;
  endproperty
  a_nop: assert property (p_nop) else $error("nop wrong");

endmodule : bit_shift_flag_unit

// [rtl/bit_shift_flag_unit_consts.svh]
// Constants for the bit, shift and flag execution unit.
// Assumes inclusion by bare name from any file that needs them.
`ifndef BIT_SHIFT_FLAG_UNIT_CONSTS_SVH
`define BIT_SHIFT_FLAG_UNIT_CONSTS_SVH

// ===========================================================
// Status register bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// ===========================================================
// Reset values and widths
`define STATUS_RESET 8'h00
`define DATA_RESET 8'h00
`define DATA_WIDTH 8

`endif

// [rtl/shift_rotate_core.sv]
// Combinational shift and rotate datapath with its Z, C, N, V results.
// Assumes the caller registers the outputs on the core clock.
`timescale 1ns/1ns
module shift_rotate_core
  import bit_shift_flag_pkg::*;
(
  input bit_shift_flag_pkg::op_e op,
  input wire logic [7:0] value,
  input wire logic carry_in,
  output logic [7:0] res,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out
);

  // ===========================================================
  // Data path
  always_comb
  begin
    res = value;
    c_out = carry_in;
    case (op)
      shift_left_logical_op:
      begin
        res = {value[6:0], 1'b0};
        c_out = value[7];
      end
      shift_right_logical_op:
      begin
        res = {1'b0, value[7:1]};
        c_out = value[0];
      end
      rotate_left_carry_op:
      begin
        res = {value[6:0], carry_in};
        c_out = value[7];
      end
      rotate_right_carry_op:
      begin
        res = {carry_in, value[7:1]};
        c_out = value[0];
      end
      shift_right_arith_op:
      begin
        res = {value[7], value[7:1]};
        c_out = value[0];
      end
      default:
      begin
        res = value;
        c_out = carry_in;
      end
    endcase
  end

  // Overflow is N xor C after the shift, as for every shift here
  assign z_out = (res == 8'h00);
  assign n_out = res[7];
  assign v_out = n_out ^ c_out;

endmodule : shift_rotate_core
